//--- src/wdtc_top.sv
// Watchdog timer control, service and status registers with bus slave
`timescale 1ns/1ps
`include "wdtc_consts.svh"

module wdtc_top #(
  parameter int TOV_W = 7
)
(
  // Clock and global reset
  input wire logic clock_i,
  input wire logic rst_i,
  // System events
  input wire logic fast_interrupt_in_i,
  input wire logic normal_interrupt_n_i,
  // Counter ticks, asynchronous
  input wire logic slow_tick_in_i,
  input wire logic test_tick_in_i,
  // Register bus
  input wire logic module_en_i,
  input wire logic byte_hi_en_i,
  input wire logic byte_lo_en_i,
  input wire logic read_write_dir_i,
  input wire logic [11:2] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic transfer_wait_ack_o,
  output logic transfer_error_ack_o,
  // Time-out actions
  output logic timeout_reset_out_o,
  output logic timeout_irq_out_o,
  output logic soft_reset_enable_o
);

  initial
  begin
    if (TOV_W != `WDTC_TOV_MSB - `WDTC_TOV_LSB + 1)
      $error("wdtc_top: TOV_W must match the time-out field");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic halt_bit;
  logic [TOV_W-1:0] timeout_value;
  logic irq_select;
  logic test_clock_select;
  logic enable_write_control;
  logic dog_enable;
  logic enable_written;
  logic [15:0] service_reg;
  logic service_armed;
  logic timeout_flag;
  logic timeout_irq_flag;
  wdtc_pkg::wdtc_state_e state;
  wdtc_pkg::wdtc_state_e next_state;
  logic [TOV_W-1:0] count;
  logic slow_rise;
  logic test_rise;
  logic tick;
  logic run;
  logic bus_rd;
  logic bus_wr;
  logic sel_ctrl;
  logic sel_svc;
  logic sel_stat;
  logic ctrl_wr_hi;
  logic ctrl_wr_lo;
  logic svc_wr;
  logic svc_good;
  logic en_may_write;
  logic enable_rise;
  logic counter_load;
  logic counter_dec;
  logic timeout_evt;
  logic stat_rd;
  logic irq_event;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_hit(input logic [11:2] a,
                                    input logic [9:0] idx);
    addr_hit = (a == idx);
  endfunction

  function automatic logic [31:0] read_word(input logic [11:2] a);
    logic [31:0] w;
    w = `WDTC_WORD_ZERO;
    if (addr_hit(a, `WDTC_CTRL_IDX))
    begin
      w[`WDTC_HALT_BIT] = halt_bit;
      w[`WDTC_TOV_MSB:`WDTC_TOV_LSB] = timeout_value;
      w[`WDTC_IRQSEL_BIT] = irq_select;
      w[`WDTC_TESTCLK_BIT] = test_clock_select;
      w[`WDTC_SWR_BIT] = soft_reset_enable_o;
      w[`WDTC_WEC_BIT] = enable_write_control;
      w[`WDTC_EN_BIT] = dog_enable;
    end
    else if (addr_hit(a, `WDTC_SVC_IDX))
      w[15:0] = service_reg;
    else if (addr_hit(a, `WDTC_STAT_IDX))
    begin
      w[`WDTC_TIRQ_BIT] = timeout_irq_flag;
      w[`WDTC_TIMEOUT_FLAG_BIT] = timeout_flag;
    end
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Tick synchronisers

  wdtc_sync u_slow_sync
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(slow_tick_in_i),
    .rise_o(slow_rise)
  );

  // Both ticks stay synchronised so switching source cannot glitch
  wdtc_sync u_test_sync
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(test_tick_in_i),
    .rise_o(test_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  always_comb
  begin
    bus_rd = module_en_i && read_write_dir_i;
    bus_wr = module_en_i && !read_write_dir_i;
    sel_ctrl = addr_hit(addr_i, `WDTC_CTRL_IDX);
    sel_svc = addr_hit(addr_i, `WDTC_SVC_IDX);
    sel_stat = addr_hit(addr_i, `WDTC_STAT_IDX);
    ctrl_wr_hi = bus_wr && sel_ctrl && byte_hi_en_i;
    ctrl_wr_lo = bus_wr && sel_ctrl && byte_lo_en_i;
    svc_wr = bus_wr && sel_svc && byte_hi_en_i && byte_lo_en_i;
    svc_good = svc_wr && service_armed
      && wdata_i[15:0] == `WDTC_SVC_SECOND;
    stat_rd = bus_rd && sel_stat;
    en_may_write = enable_write_control || !enable_written;
    enable_rise = ctrl_wr_lo && en_may_write && !dog_enable
      && wdata_i[`WDTC_EN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Counting conditions

  always_comb
  begin
    tick = test_clock_select ? test_rise : slow_rise;
    run = dog_enable && !halt_bit;
    counter_load = svc_good || enable_rise;
    timeout_evt = state == wdtc_pkg::WDTC_COUNT && run && tick
      && !counter_load && count <= TOV_W'(1);
    counter_dec = state == wdtc_pkg::WDTC_COUNT && run && tick;
    irq_event = timeout_evt && irq_select;
  end

  wdtc_counter #(
    .WIDTH(TOV_W)
  ) u_counter
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(counter_load),
    .value_i(timeout_value),
    .dec_i(counter_dec),
    .count_o(count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counter state

  always_comb
  begin
    next_state = state;
    unique case (state)
      wdtc_pkg::WDTC_IDLE:
      begin
        if (counter_load)
          next_state = wdtc_pkg::WDTC_COUNT;
      end
      wdtc_pkg::WDTC_COUNT:
      begin
        if (timeout_evt)
          next_state = wdtc_pkg::WDTC_EXPIRED;
      end
      wdtc_pkg::WDTC_EXPIRED:
      begin
        if (counter_load)
          next_state = wdtc_pkg::WDTC_COUNT;
      end
      default:
        next_state = wdtc_pkg::WDTC_IDLE;
    endcase
    if (!dog_enable && !enable_rise)
      next_state = wdtc_pkg::WDTC_IDLE;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      state <= wdtc_pkg::WDTC_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register, upper lane

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      halt_bit <= 1'b0;
      timeout_value <= `WDTC_TOV_RESET;
    end
    else
    begin
      if (ctrl_wr_hi)
      begin
        halt_bit <= wdata_i[`WDTC_HALT_BIT];
        timeout_value <= wdata_i[`WDTC_TOV_MSB:`WDTC_TOV_LSB];
      end
      // System events release the halt over any software write
      if (fast_interrupt_in_i || !normal_interrupt_n_i)
        halt_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register, lower lane

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_select <= 1'b0;
      test_clock_select <= 1'b0;
      soft_reset_enable_o <= 1'b0;
      enable_write_control <= 1'b0;
    end
    else if (ctrl_wr_lo)
    begin
      irq_select <= wdata_i[`WDTC_IRQSEL_BIT];
      test_clock_select <= wdata_i[`WDTC_TESTCLK_BIT];
      soft_reset_enable_o <= wdata_i[`WDTC_SWR_BIT];
      enable_write_control <= wdata_i[`WDTC_WEC_BIT];
    end
  end

  // Protection uses the control bit as it stood before this write
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dog_enable <= 1'b0;
      enable_written <= 1'b0;
    end
    else if (ctrl_wr_lo && en_may_write)
    begin
      dog_enable <= wdata_i[`WDTC_EN_BIT];
      enable_written <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Service register and sequence

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      service_reg <= `WDTC_SVC_RESET;
      service_armed <= 1'b0;
    end
    else if (svc_wr)
    begin
      service_reg <= wdata_i[15:0];
      service_armed <= wdata_i[15:0] == `WDTC_SVC_FIRST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags and time-out outputs

  // A time-out in the cycle of a status read stays set
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timeout_flag <= 1'b0;
      timeout_irq_flag <= 1'b0;
    end
    else
    begin
      if (timeout_evt)
        timeout_flag <= 1'b1;
      else if (stat_rd)
        timeout_flag <= 1'b0;
      if (irq_event)
        timeout_irq_flag <= 1'b1;
      else if (stat_rd)
        timeout_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timeout_reset_out_o <= 1'b0;
      timeout_irq_out_o <= 1'b0;
    end
    else
    begin
      timeout_reset_out_o <= timeout_evt && !irq_select;
      if (irq_event)
        timeout_irq_out_o <= 1'b1;
      else if (stat_rd)
        timeout_irq_out_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answers

  // No wait states: read data and error ack are registered and appear the cycle after select
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= `WDTC_WORD_ZERO;
      transfer_wait_ack_o <= 1'b0;
      transfer_error_ack_o <= 1'b0;
    end
    else
    begin
      transfer_wait_ack_o <= 1'b0;
      transfer_error_ack_o <= module_en_i
        && !(sel_ctrl || sel_svc || sel_stat);
      if (bus_rd)
        rdata_o <= read_word(addr_i);
    end
  end

endmodule // wdtc_top

//--- pkg/wdtc_consts.svh
// Register map, field positions and service codes of the watchdog control
`ifndef WDTC_CONSTS_SVH
`define WDTC_CONSTS_SVH

// Full register addresses
`define WDTC_CTRL_ADDR 32'h0020_1000
`define WDTC_SVC_ADDR 32'h0020_1004
`define WDTC_STAT_ADDR 32'h0020_1008

// Word index seen on the address bus, bits 11 to 2
`define WDTC_CTRL_IDX 10'h000
`define WDTC_SVC_IDX 10'h001
`define WDTC_STAT_IDX 10'h002

// Control register fields
`define WDTC_HALT_BIT 15
`define WDTC_TOV_MSB 14
`define WDTC_TOV_LSB 8
`define WDTC_IRQSEL_BIT 4
`define WDTC_TESTCLK_BIT 3
`define WDTC_SWR_BIT 2
`define WDTC_WEC_BIT 1
`define WDTC_EN_BIT 0

// Status register fields
`define WDTC_TIRQ_BIT 8
`define WDTC_TIMEOUT_FLAG_BIT 0

// Service sequence codes
`define WDTC_SVC_FIRST 16'h5555
`define WDTC_SVC_SECOND 16'hAAAA

// Reset values
`define WDTC_TOV_RESET 7'h00
`define WDTC_SVC_RESET 16'h0000
`define WDTC_WORD_ZERO 32'h0000_0000

`endif

//--- pkg/wdtc_pkg.sv
// Types shared by the watchdog control design
package wdtc_pkg;

  typedef enum logic [1:0]
  {
    WDTC_IDLE,
    WDTC_COUNT,
    WDTC_EXPIRED
  } wdtc_state_e;

endpackage

//--- src/wdtc_sync.sv
// Three-stage synchroniser with agreement filter and rise detect
`timescale 1ns/1ps

module wdtc_sync
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Asynchronous level in, one-cycle rise out
  input wire logic async_i,
  output logic rise_o
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  // First stage feeds only the second
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      rise_o <= 1'b0;
      if (stage2 == stage3)
      begin
        level <= stage3;
        rise_o <= stage3 && !level;
      end
    end
  end

endmodule // wdtc_sync

//--- src/wdtc_counter.sv
// Down counter with parallel load
`timescale 1ns/1ps

module wdtc_counter #(
  parameter int WIDTH = 7
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  input wire logic dec_i,
  // State
  output logic [WIDTH-1:0] count_o
);

  initial
  begin
    if (WIDTH < 1 || WIDTH > 16)
      $error("wdtc_counter: WIDTH out of range");
  end

  // Load takes priority so a service never loses to a tick
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      count_o <= '0;
    else if (load_i)
      count_o <= value_i;
    else if (dec_i && count_o != '0)
      count_o <= count_o - WIDTH'(1);
  end

endmodule // wdtc_counter

//--- verification/wdtc_tick_src.sv
// Tick source model standing in for the real-time clock module
`timescale 1ns/1ps

module wdtc_tick_src
(
  // Asynchronous ticks
  output logic slow_tick_o,
  output logic test_tick_o
);
  initial
  begin
    slow_tick_o = 1'b0;
    test_tick_o = 1'b0;
  end
  // Edges land off the clock grid, like a truly unrelated source
  task automatic pulse(input bit test, input int n);
    repeat (n)
    begin
      #83;
      if (test)
        test_tick_o = 1'b1;
      else
        slow_tick_o = 1'b1;
      #83;
      slow_tick_o = 1'b0;
      test_tick_o = 1'b0;
    end
  endtask
endmodule // wdtc_tick_src

//--- verification/wdtc_top_chk.sv
// Port-level checker for the watchdog control block
`timescale 1ns/1ps

module wdtc_top_chk #(
  parameter int TOV_W = 7
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register bus
  input wire logic module_en_i,
  input wire logic byte_lo_en_i,
  input wire logic read_write_dir_i,
  input wire logic [11:2] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rdata_o,
  input wire logic transfer_wait_ack_o,
  input wire logic transfer_error_ack_o,
  // Time-out actions
  input wire logic timeout_reset_out_o,
  input wire logic timeout_irq_out_o,
  input wire logic soft_reset_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  sequence s_stat_rd;
    module_en_i && read_write_dir_i && addr_i == 10'h002;
  endsequence
  sequence s_bad_acc;
    module_en_i && addr_i > 10'h002;
  endsequence
  property p_no_wait;
    transfer_wait_ack_o == 1'b0;
  endproperty
  property p_err_cause;
    s_bad_acc |=> transfer_error_ack_o;
  endproperty
  property p_err_only;
    transfer_error_ack_o |-> $past(module_en_i) && $past(addr_i) > 10'h002;
  endproperty
  property p_rst_pulse;
    timeout_reset_out_o |=> !timeout_reset_out_o;
  endproperty
  property p_one_action;
    $rose(timeout_irq_out_o) |-> !timeout_reset_out_o;
  endproperty
  property p_irq_clear;
    s_stat_rd ##0 timeout_irq_out_o |=> !timeout_irq_out_o;
  endproperty
  // Request must stay up until software reads status
  property p_irq_hold;
    timeout_irq_out_o && !(module_en_i && read_write_dir_i
      && addr_i == 10'h002) |=> timeout_irq_out_o;
  endproperty
  property p_swr;
    module_en_i && !read_write_dir_i && addr_i == 10'h000 && byte_lo_en_i
      |=> soft_reset_enable_o == $past(wdata_i[2]);
  endproperty
  property p_hi_zero;
    rdata_o[31:16] == 16'h0000;
  endproperty
  property p_ctrl_rsv;
    module_en_i && read_write_dir_i && addr_i == 10'h000
      |=> rdata_o[7:5] == 3'h0;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait ack");
  a_err_cause: assert property (p_err_cause) else $error("no err");
  a_err_only: assert property (p_err_only) else $error("bad err");
  a_rst_pulse: assert property (p_rst_pulse) else $error("rst len");
  a_one_action: assert property (p_one_action) else $error("both");
  a_irq_clear: assert property (p_irq_clear) else $error("irq on");
  a_irq_hold: assert property (p_irq_hold) else $error("irq off");
  a_swr: assert property (p_swr) else $error("swr out");
  a_hi_zero: assert property (p_hi_zero) else $error("hi bits");
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("rsv bits");
endmodule // wdtc_top_chk

bind wdtc_top wdtc_top_chk #(.TOV_W(TOV_W)) wdtc_top_chk_inst
(
  .clock_i(clock_i), .rst_i(rst_i), .module_en_i(module_en_i),
  .byte_lo_en_i(byte_lo_en_i), .read_write_dir_i(read_write_dir_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .transfer_wait_ack_o(transfer_wait_ack_o),
  .transfer_error_ack_o(transfer_error_ack_o),
  .timeout_reset_out_o(timeout_reset_out_o),
  .timeout_irq_out_o(timeout_irq_out_o),
  .soft_reset_enable_o(soft_reset_enable_o)
);

//--- verification/tb.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps

module tb;
  logic clock_i, rst_i, fast_i, normal_n_i, slow_tick, test_tick;
  logic module_en_i, hi_i, lo_i, rw_i;
  logic [9:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic wait_o, err_o, rst_out_o, irq_o, swr_o;
  int error_cnt = 0;
  int tests_run = 0;
  int rst_pulses = 0;
  wdtc_top wdtc_top_inst
  (
    .clock_i(clock_i), .rst_i(rst_i), .fast_interrupt_in_i(fast_i),
    .normal_interrupt_n_i(normal_n_i), .slow_tick_in_i(slow_tick),
    .test_tick_in_i(test_tick), .module_en_i(module_en_i),
    .byte_hi_en_i(hi_i), .byte_lo_en_i(lo_i), .read_write_dir_i(rw_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .transfer_wait_ack_o(wait_o), .transfer_error_ack_o(err_o),
    .timeout_reset_out_o(rst_out_o), .timeout_irq_out_o(irq_o),
    .soft_reset_enable_o(swr_o)
  );
  wdtc_tick_src wdtc_tick_src_inst
  (
    .slow_tick_o(slow_tick),
    .test_tick_o(test_tick)
  );
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Counted mid-cycle so the launching edge cannot race the count
  always @(negedge clock_i)
    if (rst_out_o === 1'b1)
      rst_pulses++;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access, held until its taking edge has passed
  task automatic bus(input logic rw, input logic [9:0] a,
                     input logic [31:0] d, input logic h, input logic l);
    @(negedge clock_i);
    module_en_i = 1'b1;
    rw_i = rw;
    addr_i = a;
    wdata_i = d;
    hi_i = h;
    lo_i = l;
    @(negedge clock_i);
    module_en_i = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0000_0000, 1'b0, 1'b0);
    chk(rdata_o, e);
  endtask
  task automatic svc(input logic [31:0] d);
    bus(1'b0, 10'h001, d, 1'b1, 1'b1);
  endtask
  task automatic ticks(input bit t, input int n);
    wdtc_tick_src_inst.pulse(t, n);
  endtask
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    rst_i = 1'b1;
    fast_i = 1'b0;
    normal_n_i = 1'b1;
    {module_en_i, hi_i, lo_i, rw_i} = 4'h0;
    addr_i = 10'h000;
    wdata_i = 32'h0000_0000;
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    rd(10'h000, 32'h0000_0000);
    rd(10'h001, 32'h0000_0000);
    rd(10'h002, 32'h0000_0000);
    bus(1'b0, 10'h000, 32'hFFFF_03E0, 1'b1, 1'b0);
    rd(10'h000, 32'h0000_0300);
    bus(1'b0, 10'h000, 32'h0000_00E5, 1'b0, 1'b1);
    rd(10'h000, 32'h0000_0305);
    chk(swr_o, 32'h0000_0001);
    bus(1'b0, 10'h000, 32'h0000_0000, 1'b0, 1'b1);
    rd(10'h000, 32'h0000_0301);
    ticks(0, 2);
    rd(10'h002, 32'h0000_0000);
    ticks(0, 1);
    rd(10'h002, 32'h0000_0001);
    chk(rst_pulses, 32'h0000_0001);
    rd(10'h002, 32'h0000_0000);
    // Out-of-order and broken service must not restart the count
    svc(32'h0000_AAAA);
    ticks(0, 3);
    rd(10'h002, 32'h0000_0000);
    svc(32'h0000_5555);
    svc(32'h0000_1234);
    svc(32'h0000_AAAA);
    ticks(0, 3);
    rd(10'h002, 32'h0000_0000);
    rd(10'h001, 32'h0000_AAAA);
    bus(1'b0, 10'h000, 32'h0000_8300, 1'b1, 1'b0);
    svc(32'h0000_5555);
    svc(32'h0000_AAAA);
    ticks(0, 4);
    rd(10'h002, 32'h0000_0000);
    rd(10'h000, 32'h0000_8301);
    @(negedge clock_i);
    fast_i = 1'b1;
    @(negedge clock_i);
    fast_i = 1'b0;
    rd(10'h000, 32'h0000_0301);
    ticks(0, 2);
    rd(10'h002, 32'h0000_0000);
    ticks(0, 1);
    rd(10'h002, 32'h0000_0001);
    bus(1'b0, 10'h000, 32'h0000_8300, 1'b1, 1'b0);
    @(negedge clock_i);
    normal_n_i = 1'b0;
    @(negedge clock_i);
    normal_n_i = 1'b1;
    rd(10'h000, 32'h0000_0301);
    bus(1'b0, 10'h000, 32'h0000_001B, 1'b0, 1'b1);
    svc(32'h0000_5555);
    svc(32'h0000_AAAA);
    ticks(0, 3);
    rd(10'h002, 32'h0000_0000);
    ticks(1, 3);
    chk(irq_o, 32'h0000_0001);
    rd(10'h002, 32'h0000_0101);
    chk(irq_o, 32'h0000_0000);
    chk(rst_pulses, 32'h0000_0002);
    bus(1'b0, 10'h000, 32'h0000_001A, 1'b0, 1'b1);
    rd(10'h000, 32'h0000_031A);
    bus(1'b1, 10'h003, 32'h0000_0000, 1'b0, 1'b0);
    chk(err_o, 32'h0000_0001);
    chk(wait_o, 32'h0000_0000);
    @(negedge clock_i);
    rst_i = 1'b1;
    @(negedge clock_i);
    rst_i = 1'b0;
    rd(10'h000, 32'h0000_0000);
    conclude();
  end
endmodule // tb
